/* File: shared/etc_pkg.sv */
// Package with register map, field positions and timing constants of the elapsed-time counter.
// Behaviour
// - 44-bit counter advances every 244 us tick.
// - Running counter plus user-visible copy, gated update.
// - Supply modes count only on chosen source.
// - Event mode counts while gate input active.
// - Power-fail blocks event-mode counting.
// - Match flag when seconds equal alarm value.
// - Match irq enable drives interrupt low.
// - Flags and interrupt work on either supply.
// - Fraction bytes at 00h and 01h.
// - Seconds at 02h-05h, low byte first.
// - Alarm at 06h-09h, low byte first.
// - Visible copy refreshed every tick while update bit set.
// - Nonzero rate select sets periodic flag.
// - Periodic flag sticky until host clears.
// - Periodic irq enable drives interrupt low.
// - Periodic intervals 244 us to 24.27 days.
// - Time writes shift periodic flag timing.
// - Square wave uses separate prescaler.
// - Oscillator disabled freezes the counter and holds the square-wave prescaler at zero; the tick divider still runs.
// - Registers undefined at first power-up.
// - Byte port with chip, output, write enables.
// - Source select: always, event, primary, battery.
// - Polarity bit selects gate active level.
// - Copy tracks count while update bit set.
// - Rate codes map to listed frequencies.
package etc_pkg;
  localparam int CNT_W  = 44;
  localparam int FRAC_W = 12;
  localparam int SEC_W  = 32;
  localparam logic [3:0] A_FRAC_LO = 4'h0;
  localparam logic [3:0] A_FRAC_HI = 4'h1;
  localparam logic [3:0] A_SEC0    = 4'h2;
  localparam logic [3:0] A_SEC3    = 4'h5;
  localparam logic [3:0] A_ALM0    = 4'h6;
  localparam logic [3:0] A_ALM3    = 4'h9;
  localparam logic [3:0] A_CFG     = 4'ha;
  localparam logic [3:0] A_RATE    = 4'hb;
  localparam logic [3:0] A_FLAGS   = 4'hc;
  localparam int B_TE = 7, B_OSC = 6, B_SRC_HI = 5, B_SRC_LO = 4;
  localparam int B_POL = 3, B_SQE = 2, B_PIE = 1, B_AIE = 0;
  localparam int B_OSF = 7, B_UIP = 6, B_PF = 1, B_MATCH_FLAG = 0;
  localparam int B_SQSYNC = 0;
  localparam logic [1:0] SRC_ALWAYS = 2'h0;
  localparam logic [1:0] SRC_EVENT  = 2'h1;
  localparam logic [1:0] SRC_PRI    = 2'h2;
  localparam logic [1:0] SRC_BAT    = 2'h3;
  localparam logic [2:0] TICK_DIV_LAST = 3'h7;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  typedef struct packed {
    logic       chip_sel_n;
    logic       out_en_n;
    logic       wr_en_n;
    logic [3:0] addr;
  } etc_bus_t;
endpackage : etc_pkg

/* File: hdl/etc_core.sv */
// Elapsed-time counter core with byte-wide register port.
module etc_core (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic       OSC_TICK_IN,
  input  wire logic       ON_BATTERY_IN,
  input  wire logic       POWER_FAIL_IN,
  input  wire logic       COUNT_GATE_IN,
  input  wire logic       CHIP_SEL_N_IN,
  input  wire logic       OUT_EN_N_IN,
  input  wire logic       WR_EN_N_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] DATA_IO_IN,
  output logic      [7:0] DATA_IO_OUT,
  output logic            DATA_IO_OE_OUT,
  output logic            INT_N_OE_OUT,
  output logic            INT_N_OUT,
  output logic            SQ_WAVE_OUT,
  output logic            SQ_WAVE_OE_OUT
);
  localparam int SW = 2;
  logic [SW-1:0] osc_s_reg, gate_s_reg, bat_s_reg, pf_s_reg, cs_s_reg, oe_s_reg, we_s_reg;
  logic [3:0]    addr_s1_reg, addr_s2_reg;
  logic [7:0]    din_s1_reg, din_s2_reg;
  logic          osc_d_reg, we_d_reg;
  logic [2:0]    div_reg, div_next;
  logic [14:0]   sq_pre_reg, sq_pre_next;
  localparam int CNT_W_L = etc_pkg::CNT_W;
  logic [CNT_W_L-1:0] run_reg, run_next, vis_reg, vis_next;
  logic          int_lvl_reg;
  logic [31:0]   alm_reg, alm_next;
  logic [7:0]    cfg_reg, cfg_next, rate_reg, rate_next;
  logic          sqsync_reg, sqsync_next;
  logic          pflag_reg, pflag_next, mflag_reg, mflag_next;
  logic          osf_reg, osf_next, uip_reg, uip_next;
  logic [7:0]    dout_reg, dout_next;
  logic          doe_reg, doe_next, irq_reg, irq_next, sq_reg, sq_next, sqoe_reg, sqoe_next;

  function automatic logic rate_hit(input logic [3:0] sel, input logic [43:0] c);
    case (sel)
      4'h1: rate_hit = 1'b1;
      4'h2: rate_hit = c[0] == 1'b0;
      4'h3: rate_hit = c[1:0] == 2'h0;
      4'h4: rate_hit = c[2:0] == 3'h0;
      4'h5: rate_hit = c[3:0] == 4'h0;
      4'h6: rate_hit = c[4:0] == 5'h00;
      4'h7: rate_hit = c[8:0] == 9'h000;
      4'h8: rate_hit = c[9:0] == 10'h000;
      4'h9: rate_hit = c[10:0] == 11'h000;
      4'ha: rate_hit = c[11:0] == 12'h000;
      4'hb: rate_hit = c[17:0] == 18'h00000;
      4'hc: rate_hit = c[23:0] == 24'h000000;
      4'hd: rate_hit = c[27:0] == 28'h0000000;
      4'he: rate_hit = c[30:0] == 31'h00000000;
      4'hf: rate_hit = c[32:0] == 33'h000000000;
      default: rate_hit = 1'b0;
    endcase
  endfunction : rate_hit

  function automatic logic [7:0] byte_of(input logic [43:0] v, input logic [3:0] a);
    case (a)
      etc_pkg::A_FRAC_LO: byte_of = {v[3:0], 4'h0};
      etc_pkg::A_FRAC_HI: byte_of = v[11:4];
      4'h2:    byte_of = v[19:12];
      4'h3:    byte_of = v[27:20];
      4'h4:    byte_of = v[35:28];
      4'h5:    byte_of = v[43:36];
      default: byte_of = 8'h00;
    endcase
  endfunction : byte_of

  logic tick, counting, wr_stb, rd_act, osc_edge, gate_act, sel_ok;
  logic [1:0] src;
  always_comb begin
    osc_edge = osc_s_reg[1] & ~osc_d_reg;
    tick     = osc_edge && div_reg == etc_pkg::TICK_DIV_LAST && cfg_reg[etc_pkg::B_OSC];
    src      = {cfg_reg[etc_pkg::B_SRC_HI], cfg_reg[etc_pkg::B_SRC_LO]};
    gate_act = gate_s_reg[1] == cfg_reg[etc_pkg::B_POL];
    case (src)
      etc_pkg::SRC_ALWAYS: sel_ok = 1'b1;
      etc_pkg::SRC_EVENT:  sel_ok = gate_act & ~pf_s_reg[1];
      etc_pkg::SRC_PRI:    sel_ok = ~bat_s_reg[1];
      etc_pkg::SRC_BAT:    sel_ok = bat_s_reg[1];
      default:             sel_ok = 1'b0;
    endcase
    counting = tick & sel_ok;
    wr_stb   = ~cs_s_reg[1] & ~we_s_reg[1] & we_d_reg & ~pf_s_reg[1];
    rd_act   = ~cs_s_reg[1] & ~oe_s_reg[1] & we_s_reg[1] & ~pf_s_reg[1];
  end

  always_comb begin
    div_next    = osc_edge ? div_reg + 3'h1 : div_reg;
    sq_pre_next = (sqsync_reg || !cfg_reg[etc_pkg::B_OSC]) ? '0 :
                  (osc_edge ? sq_pre_reg + 15'h0001 : sq_pre_reg);
    run_next    = counting ? run_reg + 44'h1 : run_reg;
    vis_next    = (cfg_reg[etc_pkg::B_TE] && tick) ? run_next : vis_reg;
    uip_next    = cfg_reg[etc_pkg::B_TE] && osc_edge && div_reg == 3'h6;
    alm_next    = alm_reg;
    cfg_next    = cfg_reg;
    rate_next   = rate_reg;
    sqsync_next = sqsync_reg;
    osf_next    = osf_reg | ~cfg_reg[etc_pkg::B_OSC];
    pflag_next  = pflag_reg;
    mflag_next  = mflag_reg;
    if (wr_stb) begin
      case (addr_s2_reg)
        etc_pkg::A_FRAC_LO: begin
          run_next[3:0] = din_s2_reg[7:4];
          sqsync_next   = din_s2_reg[etc_pkg::B_SQSYNC];
        end
        etc_pkg::A_FRAC_HI: run_next[11:4] = din_s2_reg;
        4'h2: run_next[19:12] = din_s2_reg;
        4'h3: run_next[27:20] = din_s2_reg;
        4'h4: run_next[35:28] = din_s2_reg;
        etc_pkg::A_SEC3: run_next[43:36] = din_s2_reg;
        etc_pkg::A_ALM0: alm_next[7:0] = din_s2_reg;
        4'h7: alm_next[15:8] = din_s2_reg;
        4'h8: alm_next[23:16] = din_s2_reg;
        etc_pkg::A_ALM3: alm_next[31:24] = din_s2_reg;
        etc_pkg::A_CFG:  cfg_next = din_s2_reg;
        etc_pkg::A_RATE: rate_next = din_s2_reg;
        etc_pkg::A_FLAGS: begin
          if (!din_s2_reg[etc_pkg::B_PF]) pflag_next = 1'b0;
          if (!din_s2_reg[etc_pkg::B_MATCH_FLAG]) mflag_next = 1'b0;
          osf_next = 1'b0;
        end
        default: ;
      endcase
      if (addr_s2_reg <= etc_pkg::A_SEC3) vis_next = run_next;
    end
    if (counting && rate_hit(rate_reg[7:4], run_next)) pflag_next = 1'b1;
    if (run_next[43:12] == alm_reg && counting) mflag_next = 1'b1;
  end

  always_comb begin
    dout_next = dout_reg;
    doe_next  = rd_act;
    if (rd_act) begin
      case (addr_s2_reg)
        etc_pkg::A_FRAC_LO: dout_next = {vis_reg[3:0], 3'h0, sqsync_reg};
        etc_pkg::A_ALM0:  dout_next = alm_reg[7:0];
        4'h7:             dout_next = alm_reg[15:8];
        4'h8:             dout_next = alm_reg[23:16];
        etc_pkg::A_ALM3:  dout_next = alm_reg[31:24];
        etc_pkg::A_CFG:   dout_next = cfg_reg;
        etc_pkg::A_RATE:  dout_next = rate_reg;
        etc_pkg::A_FLAGS: dout_next = {osf_reg, uip_reg, 4'h0, pflag_reg, mflag_reg};
        default:          dout_next = byte_of(vis_reg, addr_s2_reg);
      endcase
    end
    irq_next  = (pflag_reg & cfg_reg[etc_pkg::B_PIE]) | (mflag_reg & cfg_reg[etc_pkg::B_AIE]);
    sqoe_next = ~pf_s_reg[1];
    sq_next   = cfg_reg[etc_pkg::B_SQE] &&
                (rate_reg[3:0] == 4'h0 ? osc_s_reg[1] : sq_pre_reg[rate_reg[3:0] + 4'h1 - 4'h2 + 4'h1 - 4'h1]);
  end

  // Reset is an elaboration convenience; register contents are otherwise unspecified.
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      osc_s_reg <= '0; gate_s_reg <= '0; bat_s_reg <= '0; pf_s_reg <= '0;
      cs_s_reg <= '1; oe_s_reg <= '1; we_s_reg <= '1;
      addr_s1_reg <= '0; addr_s2_reg <= '0; din_s1_reg <= '0; din_s2_reg <= '0;
      osc_d_reg <= 1'b0; we_d_reg <= 1'b1; div_reg <= '0; sq_pre_reg <= '0;
      run_reg <= '0; vis_reg <= '0; alm_reg <= '0;
      cfg_reg <= etc_pkg::CFG_RESET; rate_reg <= etc_pkg::RATE_RESET;
      sqsync_reg <= 1'b0; pflag_reg <= 1'b0; mflag_reg <= 1'b0;
      osf_reg <= 1'b1; uip_reg <= 1'b0;
      dout_reg <= '0; doe_reg <= 1'b0; irq_reg <= 1'b0; sq_reg <= 1'b0; sqoe_reg <= 1'b0;
      int_lvl_reg <= 1'b0;
    end else begin
      int_lvl_reg <= 1'b0;
      osc_s_reg <= {osc_s_reg[0], OSC_TICK_IN};
      gate_s_reg <= {gate_s_reg[0], COUNT_GATE_IN};
      bat_s_reg <= {bat_s_reg[0], ON_BATTERY_IN};
      pf_s_reg <= {pf_s_reg[0], POWER_FAIL_IN};
      cs_s_reg <= {cs_s_reg[0], CHIP_SEL_N_IN};
      oe_s_reg <= {oe_s_reg[0], OUT_EN_N_IN};
      we_s_reg <= {we_s_reg[0], WR_EN_N_IN};
      addr_s1_reg <= ADDR_IN; addr_s2_reg <= addr_s1_reg;
      din_s1_reg <= DATA_IO_IN; din_s2_reg <= din_s1_reg;
      osc_d_reg <= osc_s_reg[1]; we_d_reg <= we_s_reg[1];
      div_reg <= div_next; sq_pre_reg <= sq_pre_next;
      run_reg <= run_next; vis_reg <= vis_next; alm_reg <= alm_next;
      cfg_reg <= cfg_next; rate_reg <= rate_next; sqsync_reg <= sqsync_next;
      pflag_reg <= pflag_next; mflag_reg <= mflag_next;
      osf_reg <= osf_next; uip_reg <= uip_next;
      dout_reg <= dout_next; doe_reg <= doe_next; irq_reg <= irq_next;
      sq_reg <= sq_next; sqoe_reg <= sqoe_next;
    end
  end

  assign DATA_IO_OUT    = dout_reg;
  assign DATA_IO_OE_OUT = doe_reg;
  assign INT_N_OUT      = int_lvl_reg;
  assign INT_N_OE_OUT   = irq_reg;
  assign SQ_WAVE_OUT    = sq_reg;
  assign SQ_WAVE_OE_OUT = sqoe_reg;

  property p_run_step;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) counting && !wr_stb |=> run_reg == $past(run_reg) + 44'h1;
  endproperty
  a_run_step: assert property (p_run_step) else $error("Counter did not step.");
  property p_frozen;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) !cfg_reg[etc_pkg::B_OSC] && !wr_stb |=> $stable(run_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Counter moved with oscillator off.");
  property p_pf_block;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) src == etc_pkg::SRC_EVENT && pf_s_reg[1] |-> !counting;
  endproperty
  a_pf_block: assert property (p_pf_block) else $error("Counted during power fail.");
  property p_gate;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) src == etc_pkg::SRC_EVENT && !gate_act |-> !counting;
  endproperty
  a_gate: assert property (p_gate) else $error("Counted with gate inactive.");
  property p_irq;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) mflag_reg && cfg_reg[etc_pkg::B_AIE] |=> INT_N_OE_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("Match interrupt not driven.");
  property p_pirq;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) pflag_reg && cfg_reg[etc_pkg::B_PIE] |=> INT_N_OE_OUT;
  endproperty
  a_pirq: assert property (p_pirq) else $error("Periodic interrupt not driven.");
  property p_sticky;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) pflag_reg && !wr_stb |=> pflag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Periodic flag dropped.");
  property p_copy;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) cfg_reg[etc_pkg::B_TE] && tick && !wr_stb |=> vis_reg == run_reg;
  endproperty
  a_copy: assert property (p_copy) else $error("Visible copy not refreshed.");
  c_irq:   cover property (@(posedge CORE_CLK_IN) INT_N_OE_OUT);
  c_match: cover property (@(posedge CORE_CLK_IN) mflag_reg);
  c_read:  cover property (@(posedge CORE_CLK_IN) doe_reg);
endmodule : etc_core

/* File: dv/etc_host_model.sv */
// Host processor model that drives the byte-wide register port.
module etc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  output logic            cs_n_out,
  output logic            oe_n_out,
  output logic            we_n_out,
  output logic      [3:0] addr_out,
  output logic      [7:0] bus_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] host_data = 8'h00;
  logic       host_drive = 1'b0;
  initial begin
    cs_n_out = 1'b1;
    oe_n_out = 1'b1;
    we_n_out = 1'b1;
    addr_out = 4'h0;
  end
  // A released bus shows the inverse of the last host value.
  assign bus_data_out = dev_oe_in ? dev_data_in : (host_drive ? host_data : ~host_data);
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_cyc
  // Address and data settle before the strobes and hold past them.
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    addr_out = a;
    host_data = d;
    host_drive = 1'b1;
    wait_cyc(5);
    cs_n_out = 1'b0;
    we_n_out = 1'b0;
    wait_cyc(8);
    we_n_out = 1'b1;
    cs_n_out = 1'b1;
    wait_cyc(4);
    host_drive = 1'b0;
    wait_cyc(4);
  endtask : write_byte
  task automatic read_byte(input logic [3:0] a, output logic [7:0] d);
    addr_out = a;
    wait_cyc(5);
    cs_n_out = 1'b0;
    oe_n_out = 1'b0;
    wait_cyc(8);
    d = dev_data_in;
    cs_n_out = 1'b1;
    oe_n_out = 1'b1;
    wait_cyc(8);
  endtask : read_byte
endmodule : etc_host_model

/* File: dv/etc_core_tb.sv */
// Self-checking testbench of the elapsed-time counter core.
module etc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       osc = 1'b0;
  logic       on_batt = 1'b0;
  logic       pwr_fail = 1'b0;
  logic       gate = 1'b0;
  logic       cs_n;
  logic       oe_n;
  logic       we_n;
  logic [3:0] addr;
  logic [7:0] din;
  logic [7:0] dout;
  logic [7:0] rd;
  logic       dout_oe;
  logic       int_oe;
  logic       int_n;
  logic       sq;
  logic       sq_oe;
  int         mismatches = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #5 clk = ~clk;
  // Fast oscillator stand-in so that a counting tick comes every 160 cycles.
  always #100 osc = ~osc;
  etc_host_model host (.clk_in(clk), .dev_data_in(dout), .dev_oe_in(dout_oe), .cs_n_out(cs_n),
    .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr), .bus_data_out(din));
  etc_core dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .OSC_TICK_IN(osc), .ON_BATTERY_IN(on_batt),
    .POWER_FAIL_IN(pwr_fail), .COUNT_GATE_IN(gate), .CHIP_SEL_N_IN(cs_n), .OUT_EN_N_IN(oe_n),
    .WR_EN_N_IN(we_n), .ADDR_IN(addr), .DATA_IO_IN(din), .DATA_IO_OUT(dout),
    .DATA_IO_OE_OUT(dout_oe), .INT_N_OE_OUT(int_oe), .INT_N_OUT(int_n), .SQ_WAVE_OUT(sq),
    .SQ_WAVE_OE_OUT(sq_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.write_byte(a, d);
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    host.read_byte(a, rd);
    check(rd & m, exp);
  endtask : rchk
  // Clears the fraction, counts under the given conditions, freezes and reports any advance.
  task automatic run_case(input logic [7:0] cfg, input logic bat, pf, g, moves);
    logic [7:0] lo;
    wr(etc_pkg::A_FRAC_HI, 8'h00);
    wr(etc_pkg::A_FRAC_LO, 8'h00);
    on_batt = bat;
    gate = g & ~pf;
    wr(etc_pkg::A_CFG, cfg);
    pwr_fail = pf;
    gate = g;
    host.wait_cyc(1000);
    check({7'h00, sq_oe}, {7'h00, ~pf});
    check({7'h00, sq}, 8'h00);
    gate = g & ~pf;
    pwr_fail = 1'b0;
    wr(etc_pkg::A_CFG, 8'h80);
    host.read_byte(etc_pkg::A_FRAC_LO, lo);
    host.read_byte(etc_pkg::A_FRAC_HI, rd);
    check({7'h00, {rd, lo[7:4]} != 12'h000}, {7'h00, moves});
    host.read_byte(etc_pkg::A_FRAC_LO, rd);
    check(rd, lo);
  endtask : run_case
  initial begin
    host.wait_cyc(10);
    rst_n = 1'b1;
    host.wait_cyc(3);
    rchk(etc_pkg::A_CFG, 8'hff, etc_pkg::CFG_RESET);
    rchk(etc_pkg::A_RATE, 8'hff, etc_pkg::RATE_RESET);
    rchk(etc_pkg::A_FLAGS, 8'h80, 8'h80);
    rchk(4'hd, 8'hff, 8'h00);
    wr(etc_pkg::A_FRAC_HI, 8'ha5);
    wr(etc_pkg::A_FRAC_LO, 8'h5e);
    rchk(etc_pkg::A_FRAC_LO, 8'hff, 8'h50);
    rchk(etc_pkg::A_FRAC_HI, 8'hff, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      wr(etc_pkg::A_SEC0 + 4'(i), 8'h10 + 8'(i));
      wr(etc_pkg::A_ALM0 + 4'(i), 8'h10 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      rchk(etc_pkg::A_SEC0 + 4'(i), 8'hff, 8'h10 + 8'(i));
      rchk(etc_pkg::A_ALM0 + 4'(i), 8'hff, 8'h10 + 8'(i));
    end
    wr(etc_pkg::A_FLAGS, 8'h00);
    on_batt = 1'b1;
    wr(etc_pkg::A_CFG, 8'hc1);
    host.wait_cyc(400);
    rchk(etc_pkg::A_FLAGS, 8'h01, 8'h01);
    check({7'h00, int_oe}, 8'h01);
    check({7'h00, int_n}, 8'h00);
    wr(etc_pkg::A_CFG, 8'hc0);
    check({7'h00, int_oe}, 8'h00);
    wr(etc_pkg::A_CFG, 8'hc2);
    wr(etc_pkg::A_FLAGS, 8'h00);
    host.wait_cyc(400);
    rchk(etc_pkg::A_FLAGS, 8'h02, 8'h00);
    check({7'h00, int_oe}, 8'h00);
    wr(etc_pkg::A_RATE, 8'h10);
    host.wait_cyc(400);
    rchk(etc_pkg::A_FLAGS, 8'h02, 8'h02);
    check({7'h00, int_oe}, 8'h01);
    wr(etc_pkg::A_CFG, 8'h82);
    wr(etc_pkg::A_FLAGS, 8'h00);
    rchk(etc_pkg::A_FLAGS, 8'h02, 8'h00);
    check({7'h00, int_oe}, 8'h00);
    wr(etc_pkg::A_CFG, 8'hc2);
    host.wait_cyc(400);
    rchk(etc_pkg::A_FLAGS, 8'h02, 8'h02);
    wr(etc_pkg::A_RATE, 8'h00);
    run_case(8'hc0, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'h80, 1'b0, 1'b0, 1'b1, 1'b0);
    run_case(8'hd8, 1'b0, 1'b0, 1'b1, 1'b1);
    run_case(8'hd8, 1'b0, 1'b0, 1'b0, 1'b0);
    run_case(8'hd0, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'hd8, 1'b0, 1'b1, 1'b1, 1'b0);
    run_case(8'he0, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'he0, 1'b1, 1'b0, 1'b0, 1'b0);
    run_case(8'hf0, 1'b1, 1'b0, 1'b0, 1'b1);
    run_case(8'hf0, 1'b0, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : etc_core_tb
